// [pwm_timer_pkg.sv]
/*
  Constants for the three-output pulse-width block: register indices and
  banks, field positions, reset values and bus encodings.
  Assumes hclk is the oscillator clock, so one hclk period is one
  quarter-cycle and four of them make one instruction cycle.
*/
package pwm_timer_pkg;

  // banks, byte address = bank * 0x100 + index * 4
  localparam logic [2:0] BANK_FLAGS = 3'h1;
  localparam logic [2:0] BANK_TIMER = 3'h2;
  localparam logic [2:0] BANK_PWM = 3'h3;
  localparam logic [2:0] BANK_PWM_C = 3'h7;

  // register indices
  localparam logic [5:0] IDX_PERIPHERAL_FLAGS_ONE = 6'h16;
  localparam logic [5:0] IDX_PERIPHERAL_ENABLES_ONE = 6'h17;
  localparam logic [5:0] IDX_TIMER_ONE_COUNT = 6'h10;
  localparam logic [5:0] IDX_TIMER_TWO_COUNT = 6'h11;
  localparam logic [5:0] IDX_TIMER_ONE_PERIOD = 6'h14;
  localparam logic [5:0] IDX_TIMER_TWO_PERIOD = 6'h15;
  localparam logic [5:0] IDX_DUTY_LOW_FIRST = 6'h10;
  localparam logic [5:0] IDX_DUTY_LOW_SECOND = 6'h11;
  localparam logic [5:0] IDX_DUTY_HIGH_FIRST = 6'h12;
  localparam logic [5:0] IDX_DUTY_HIGH_SECOND = 6'h13;
  localparam logic [5:0] IDX_TIMER_CONTROL_ONE = 6'h16;
  localparam logic [5:0] IDX_TIMER_CONTROL_TWO = 6'h17;
  localparam logic [5:0] IDX_DUTY_LOW_THIRD = 6'h10;
  localparam logic [5:0] IDX_DUTY_HIGH_THIRD = 6'h11;
  localparam logic [5:0] IDX_TIMER_CONTROL_THREE = 6'h16;

  // field positions
  localparam int BIT_CLOCK_SOURCE = 0;
  localparam int BIT_RUN = 0;
  localparam int BIT_PULSE_A_ENABLE = 4;
  localparam int BIT_PULSE_B_ENABLE = 5;
  localparam int BIT_PULSE_C_ENABLE = 0;
  localparam int BIT_BASE_SELECT = 5;
  localparam int BIT_TIMER_FLAG = 4;
  localparam int DUTY_LOW_LSB = 6;

  // read masks for bits outside this block
  localparam logic [7:0] MASK_CONTROL_TWO = 8'h3f;
  localparam logic [7:0] MASK_CONTROL_THREE = 8'h1f;

  // reset values
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_ENABLES = 8'h00;
  localparam logic [7:0] RESET_DATA = 8'h00;

  // quarter-cycle phase that ends an instruction cycle
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // bus encodings
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [11:0] ADDR_UNMAPPED = 12'hfff;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_READ_WAIT = 4'b0100,
    BUS_READ_DONE = 4'b1000
  } bus_state_type;

endpackage

// [triple_pwm_timer_base.sv]
/*
  Three pulse-width outputs on two 8-bit timers, with an AHB-Lite
  register slave, double-buffered duty registers and pin muxing.
  Assumes hclk is the oscillator clock, all inputs are synchronous to
  hclk, and one master with this as the only slave.
*/
`timescale 1ns/1ps

// Behaviour
// R1: three outputs, 10-bit duty, from always low to always high.
// R2: output a uses timer one; b and c choose timer one or two.
// R3: output b uses timer two when its low duty register bit 5 is set.
// R4: output c uses timer two when its low duty register bit 5 is set.
// R5: control two bit 4 drives pin a as pulse output, else port pin.
// R6: control two bit 5 likewise for pin b, control three bit 0 for c.
// R7: period is selected period value plus one, times four oscillator periods.
// R8: duty value is high register then low register bits 7:6.
// R9: high time equals duty value oscillator periods.
// R10: duty value zero keeps output low.
// R11: high register equal to period gives one to four low clocks.
// R12: high register above period keeps output high all period.
// R13: writes go to master; rollover copies to slave and raises output.
// R14: duty register reads return the slave latch.
// R15: software avoids read-modify-write on duty registers.
// R16: timer equal to period clears next increment and sets its flag.
// R17: software clears the timer flags.
// R18: external clock sampled once per instruction cycle; edges may shift.
// R19: software keeps low duty bits zero with external clock.
// R20: software never uses combined timer mode with outputs active.
// R21: timer counts up from zero to period then back to zero.
// R22: source bit clear counts per instruction cycle, set on external falls.
// R23: timer with run bit clear neither counts nor sets its flag.
// R24: phase counter extends timer to 10 bits for duty compare.
module triple_pwm_timer_base (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic shared_ext_timer_clock,
  input wire logic [2:0] port_data_bits,
  input wire logic [2:0] port_direction_bits,
  output logic pulse_out_a,
  output logic pulse_out_b,
  output logic pulse_out_c,
  output logic pulse_a_oe,
  output logic pulse_b_oe,
  output logic pulse_c_oe,
  output logic timer_one_flag,
  output logic timer_two_flag
);

  typedef struct packed {
    pwm_timer_pkg::bus_state_type bus;
    logic [11:0] addr;
    logic [31:0] rdata;
    logic [1:0] phase;
    logic ext;
    logic [1:0][7:0] cnt;
    logic [1:0][7:0] pr;
    logic [1:0] flag;
    logic [7:0] timer_control_one;
    logic [7:0] timer_control_two;
    logic [7:0] timer_control_three;
    logic [7:0] peripheral_enables_one;
    logic [2:0][7:0] dch_m;
    logic [2:0][1:0] dcl_m;
    logic [2:0][7:0] dch_s;
    logic [2:0][1:0] dcl_s;
    logic [2:0] sel;
    logic [2:0] pwm;
    logic [2:0] pin;
    logic [2:0] oe;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic wr;
  logic accept;
  logic icy_end;
  logic [1:0] tick;
  logic [1:0] roll;
  logic [2:0] base;
  logic [2:0] en;
  logic [7:0] wb;

  function automatic logic hit(input logic [11:0] a, input logic [2:0] b,
                               input logic [5:0] i);
    return a == {1'b0, b, i, 2'b00};
  endfunction

  function automatic logic [7:0] read_byte(input state_type s, input logic [11:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (hit(a, pwm_timer_pkg::BANK_FLAGS, pwm_timer_pkg::IDX_PERIPHERAL_FLAGS_ONE)) begin
      r[pwm_timer_pkg::BIT_TIMER_FLAG +: 2] = s.flag;
    end else if (hit(a, pwm_timer_pkg::BANK_FLAGS,
                     pwm_timer_pkg::IDX_PERIPHERAL_ENABLES_ONE)) begin
      r = s.peripheral_enables_one;
    end else if (hit(a, pwm_timer_pkg::BANK_TIMER, pwm_timer_pkg::IDX_TIMER_ONE_COUNT)) begin
      r = s.cnt[0];
    end else if (hit(a, pwm_timer_pkg::BANK_TIMER, pwm_timer_pkg::IDX_TIMER_TWO_COUNT)) begin
      r = s.cnt[1];
    end else if (hit(a, pwm_timer_pkg::BANK_TIMER, pwm_timer_pkg::IDX_TIMER_ONE_PERIOD)) begin
      r = s.pr[0];
    end else if (hit(a, pwm_timer_pkg::BANK_TIMER, pwm_timer_pkg::IDX_TIMER_TWO_PERIOD)) begin
      r = s.pr[1];
    end else if (hit(a, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_DUTY_LOW_FIRST)) begin
      r = {s.dcl_s[0], 6'h00}; // [R14]
    end else if (hit(a, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_DUTY_LOW_SECOND)) begin
      r = {s.dcl_s[1], s.sel[1], 5'h00}; // [R14]
    end else if (hit(a, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_DUTY_HIGH_FIRST)) begin
      r = s.dch_s[0]; // [R14]
    end else if (hit(a, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_DUTY_HIGH_SECOND)) begin
      r = s.dch_s[1]; // [R14]
    end else if (hit(a, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_TIMER_CONTROL_ONE)) begin
      r = s.timer_control_one;
    end else if (hit(a, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_TIMER_CONTROL_TWO)) begin
      r = s.timer_control_two & pwm_timer_pkg::MASK_CONTROL_TWO;
    end else if (hit(a, pwm_timer_pkg::BANK_PWM_C, pwm_timer_pkg::IDX_DUTY_LOW_THIRD)) begin
      r = {s.dcl_s[2], s.sel[2], 5'h00}; // [R14]
    end else if (hit(a, pwm_timer_pkg::BANK_PWM_C, pwm_timer_pkg::IDX_DUTY_HIGH_THIRD)) begin
      r = s.dch_s[2]; // [R14]
    end else if (hit(a, pwm_timer_pkg::BANK_PWM_C,
                     pwm_timer_pkg::IDX_TIMER_CONTROL_THREE)) begin
      r = s.timer_control_three & pwm_timer_pkg::MASK_CONTROL_THREE;
    end
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    wb = hwdata[7:0];
    wr = (s_q.bus == pwm_timer_pkg::BUS_WRITE);
    accept = hsel && hready && htrans[1] && (hsize == pwm_timer_pkg::SIZE_WORD);

    // bus sequencing, reads take one wait state
    case (s_q.bus)
      pwm_timer_pkg::BUS_READ_WAIT: begin
        s_d.bus = pwm_timer_pkg::BUS_READ_DONE;
        s_d.rdata = {24'h000000, read_byte(s_q, s_q.addr)};
      end
      pwm_timer_pkg::BUS_IDLE, pwm_timer_pkg::BUS_WRITE,
      pwm_timer_pkg::BUS_READ_DONE: begin
        if (accept) begin
          s_d.bus = hwrite ? pwm_timer_pkg::BUS_WRITE : pwm_timer_pkg::BUS_READ_WAIT;
          s_d.addr = (haddr[31:12] == 20'h00000) ? haddr[11:0]
                                                 : pwm_timer_pkg::ADDR_UNMAPPED;
        end else begin
          s_d.bus = pwm_timer_pkg::BUS_IDLE;
        end
      end
      default: begin
        s_d.bus = pwm_timer_pkg::BUS_IDLE;
      end
    endcase

    // control and duty writes
    if (wr) begin
      if (hit(s_q.addr, pwm_timer_pkg::BANK_FLAGS, pwm_timer_pkg::IDX_PERIPHERAL_FLAGS_ONE)) begin
        s_d.flag = wb[pwm_timer_pkg::BIT_TIMER_FLAG +: 2];
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_FLAGS,
              pwm_timer_pkg::IDX_PERIPHERAL_ENABLES_ONE)) begin
        s_d.peripheral_enables_one = wb;
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_TIMER, pwm_timer_pkg::IDX_TIMER_ONE_PERIOD)) begin
        s_d.pr[0] = wb;
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_TIMER, pwm_timer_pkg::IDX_TIMER_TWO_PERIOD)) begin
        s_d.pr[1] = wb;
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_TIMER_CONTROL_ONE)) begin
        s_d.timer_control_one = wb;
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_TIMER_CONTROL_TWO)) begin
        s_d.timer_control_two = wb;
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_PWM_C, pwm_timer_pkg::IDX_TIMER_CONTROL_THREE)) begin
        s_d.timer_control_three = wb;
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_DUTY_HIGH_FIRST)) begin
        s_d.dch_m[0] = wb; // [R13]
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_DUTY_HIGH_SECOND)) begin
        s_d.dch_m[1] = wb; // [R13]
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_PWM_C, pwm_timer_pkg::IDX_DUTY_HIGH_THIRD)) begin
        s_d.dch_m[2] = wb; // [R13]
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_DUTY_LOW_FIRST)) begin
        s_d.dcl_m[0] = wb[pwm_timer_pkg::DUTY_LOW_LSB +: 2]; // [R13]
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_DUTY_LOW_SECOND)) begin
        s_d.dcl_m[1] = wb[pwm_timer_pkg::DUTY_LOW_LSB +: 2]; // [R13]
        s_d.sel[1] = wb[pwm_timer_pkg::BIT_BASE_SELECT]; // [R3]
      end
      if (hit(s_q.addr, pwm_timer_pkg::BANK_PWM_C, pwm_timer_pkg::IDX_DUTY_LOW_THIRD)) begin
        s_d.dcl_m[2] = wb[pwm_timer_pkg::DUTY_LOW_LSB +: 2]; // [R13]
        s_d.sel[2] = wb[pwm_timer_pkg::BIT_BASE_SELECT]; // [R4]
      end
    end

    // quarter-cycle phase and once-per-cycle sample of the external clock
    s_d.phase = s_q.phase + 2'h1; // [R24]
    icy_end = (s_q.phase == pwm_timer_pkg::PHASE_LAST);
    if (icy_end) begin
      s_d.ext = shared_ext_timer_clock; // [R18]
    end

    // timers, flag set wins over a software clear
    for (int i = 0; i < 2; i++) begin
      tick[i] = s_q.timer_control_two[pwm_timer_pkg::BIT_RUN + i] && icy_end && // [R23]
                (!s_q.timer_control_one[pwm_timer_pkg::BIT_CLOCK_SOURCE + i] || // [R22]
                 (s_q.ext && !shared_ext_timer_clock)); // [R18]
      roll[i] = tick[i] && (s_q.cnt[i] == s_q.pr[i]); // [R7] [R16]
      if (tick[i]) begin
        s_d.cnt[i] = roll[i] ? 8'h00 : s_q.cnt[i] + 8'h01; // [R21]
      end
      if (roll[i]) begin
        s_d.flag[i] = 1'b1; // [R16]
      end
    end

    // a software count write wins over an increment
    if (wr && hit(s_q.addr, pwm_timer_pkg::BANK_TIMER, pwm_timer_pkg::IDX_TIMER_ONE_COUNT)) begin
      s_d.cnt[0] = wb;
    end
    if (wr && hit(s_q.addr, pwm_timer_pkg::BANK_TIMER, pwm_timer_pkg::IDX_TIMER_TWO_COUNT)) begin
      s_d.cnt[1] = wb;
    end

    // outputs
    en[0] = s_d.timer_control_two[pwm_timer_pkg::BIT_PULSE_A_ENABLE];
    en[1] = s_d.timer_control_two[pwm_timer_pkg::BIT_PULSE_B_ENABLE];
    en[2] = s_d.timer_control_three[pwm_timer_pkg::BIT_PULSE_C_ENABLE];
    for (int k = 0; k < 3; k++) begin
      base[k] = (k != 0) && s_q.sel[k]; // [R2]
      if (roll[base[k]]) begin
        s_d.dch_s[k] = s_q.dch_m[k]; // [R13]
        s_d.dcl_s[k] = s_q.dcl_m[k]; // [R13]
      end
      // high while the 10-bit count is below the duty value
      s_d.pwm[k] = {s_d.cnt[base[k]], s_d.phase} < // [R1] [R9] [R10] [R11] [R12]
                   {s_d.dch_s[k], s_d.dcl_s[k]}; // [R8]
      s_d.pin[k] = en[k] ? s_d.pwm[k] : port_data_bits[k]; // [R5] [R6]
      s_d.oe[k] = en[k] || !port_direction_bits[k]; // [R5] [R6]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.bus <= pwm_timer_pkg::BUS_IDLE;
      s_q.timer_control_one <= pwm_timer_pkg::RESET_CONTROL;
      s_q.timer_control_two <= pwm_timer_pkg::RESET_CONTROL;
      s_q.timer_control_three <= pwm_timer_pkg::RESET_CONTROL;
      s_q.peripheral_enables_one <= pwm_timer_pkg::RESET_ENABLES;
      s_q.cnt <= {2{pwm_timer_pkg::RESET_DATA}};
      s_q.pr <= {2{pwm_timer_pkg::RESET_DATA}};
      s_q.dch_m <= {3{pwm_timer_pkg::RESET_DATA}};
      s_q.dch_s <= {3{pwm_timer_pkg::RESET_DATA}};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign hreadyout = ce && (s_q.bus != pwm_timer_pkg::BUS_READ_WAIT);
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign pulse_out_a = s_q.pin[0];
  assign pulse_out_b = s_q.pin[1];
  assign pulse_out_c = s_q.pin[2];
  assign pulse_a_oe = s_q.oe[0];
  assign pulse_b_oe = s_q.oe[1];
  assign pulse_c_oe = s_q.oe[2];
  assign timer_one_flag = s_q.flag[0];
  assign timer_two_flag = s_q.flag[1];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence seq_roll_a;
    ce && roll[0];
  endsequence

  sequence seq_read_accept;
    ce && accept && !hwrite && hreadyout;
  endsequence

  sequence seq_roll_b;
    ce && roll[1];
  endsequence

  sequence seq_roll_b_sel;
    ce && roll[1] && s_q.sel[1];
  endsequence

  // timers

  a_timer_rollover: assert property (ce && roll[0] && !wr |=> // [R16]
    s_q.cnt[0] == 8'h00 && s_q.flag[0]) else $error("timer one missed rollover");
  a_timer_stopped: assert property (ce && !s_q.timer_control_two[0] && !wr |=> // [R23]
    $stable(s_q.cnt[0]) && !$rose(s_q.flag[0])) else $error("stopped timer moved");
  a_tick_internal: assert property (ce && tick[0] && !s_q.timer_control_one[0] && !wr && // [R22]
    s_q.cnt[0] != s_q.pr[0] |=> s_q.phase == 2'h0 &&
    s_q.cnt[0] == $past(s_q.cnt[0]) + 8'h01) else $error("internal tick missed");
  a_tick_external: assert property (ce && s_q.timer_control_two[1] && s_q.timer_control_one[1] && icy_end && // [R18]
    s_q.ext && !shared_ext_timer_clock && s_q.cnt[1] != s_q.pr[1] && !wr |=>
    s_q.cnt[1] == $past(s_q.cnt[1]) + 8'h01) else $error("external fall not counted");
  a_external_idle: assert property (ce && s_q.timer_control_one[1] && !wr && // [R22]
    !(icy_end && s_q.ext && !shared_ext_timer_clock) |=> $stable(s_q.cnt[1]))
    else $error("external timer moved without fall");
  a_count_phase: assert property (ce && s_q.phase != 2'h3 && !wr |=> // [R22]
    $stable(s_q.cnt)) else $error("timer moved off cycle boundary");
  a_timer_two_stopped: assert property (ce && !s_q.timer_control_two[1] && !wr |=> // [R23]
    $stable(s_q.cnt[1]) && !$rose(s_q.flag[1])) else $error("stopped timer two moved");
  a_flag_sticky: assert property (ce && s_q.flag[1] && !wr |=> // [R16]
    s_q.flag[1]) else $error("timer two flag cleared by itself");
  a_flag_set_wins: assert property (seq_roll_b |=> s_q.flag[1]) // [R16]
    else $error("timer two flag not set at rollover");

  // duty buffering
  a_slave_transfer: assert property (seq_roll_a |=> // [R13]
    s_q.dch_s[0] == $past(s_q.dch_m[0]) && s_q.dcl_s[0] == $past(s_q.dcl_m[0]))
    else $error("slave not loaded at rollover");
  a_slave_hold: assert property (ce && !roll[0] |=> // [R14]
    $stable(s_q.dch_s[0])) else $error("slave changed mid period");
  a_period_start: assert property (seq_roll_a |=> // [R7]
    s_q.phase == 2'h0 && s_q.pwm[0] == (s_q.dch_s[0] != 8'h00 || s_q.dcl_s[0] != 2'h0))
    else $error("period start wrong");
  a_zero_duty: assert property (s_q.dch_s[1] == 8'h00 && s_q.dcl_s[1] == 2'h0 |-> // [R10]
    !s_q.pwm[1]) else $error("zero duty not low");
  a_full_on: assert property (s_q.dch_s[0] > s_q.pr[0] && s_q.cnt[0] <= s_q.pr[0] |-> // [R12]
    s_q.pwm[0]) else $error("full duty not high");
  a_pin_forced: assert property (s_q.timer_control_two[4] |-> // [R5]
    pulse_a_oe && pulse_out_a == s_q.pwm[0]) else $error("pin a not driven by pulse");
  a_pin_port: assert property (!s_q.timer_control_three[0] && $past(ce) |-> // [R6]
    pulse_out_c == $past(port_data_bits[2])) else $error("pin c not port data");
  a_read_wait: assert property (seq_read_accept ##1 ce |-> // [R14]
    !hreadyout ##1 s_q.bus == pwm_timer_pkg::BUS_READ_DONE) else $error("read wait wrong");
  a_read_data: assert property (ce && s_q.bus == pwm_timer_pkg::BUS_READ_WAIT && // [R14]
    hit(s_q.addr, pwm_timer_pkg::BANK_PWM, pwm_timer_pkg::IDX_DUTY_HIGH_FIRST) |=>
    hrdata == {24'h000000, $past(s_q.dch_s[0])})
    else $error("duty read not from slave");

  // time base selection and slave loads
  a_base_b_two: assert property (seq_roll_b_sel |=> // [R3]
    s_q.dch_s[1] == $past(s_q.dch_m[1])) else $error("output b missed timer two load");
  a_base_c_one: assert property (ce && roll[0] && !s_q.sel[2] |=> // [R4]
    s_q.dch_s[2] == $past(s_q.dch_m[2])) else $error("output c missed timer one load");
  a_slave_hold_b: assert property (ce && !roll[s_q.sel[1]] |=> // [R2]
    $stable(s_q.dch_s[1])) else $error("output b slave changed mid period");
  a_high_equal: assert property (s_q.dch_s[0] == s_q.pr[0] && // [R11]
    s_q.cnt[0] == s_q.pr[0] |-> s_q.pwm[0] == (s_q.phase < s_q.dcl_s[0]))
    else $error("equal duty low time wrong");

  // pins
  a_pin_b_forced: assert property (s_q.timer_control_two[5] |-> // [R6]
    pulse_b_oe && pulse_out_b == s_q.pwm[1]) else $error("pin b not driven by pulse");
  a_pin_c_forced: assert property (s_q.timer_control_three[0] |-> // [R6]
    pulse_c_oe && pulse_out_c == s_q.pwm[2]) else $error("pin c not driven by pulse");
  a_pin_port_b: assert property (!s_q.timer_control_two[5] && $past(ce) && $past(hresetn) |-> // [R6]
    pulse_out_b == $past(port_data_bits[1])) else $error("pin b not port data");
  a_oe_port: assert property (!s_q.timer_control_two[4] && $past(ce) && $past(hresetn) |-> // [R5]
    pulse_a_oe == !$past(port_direction_bits[0])) else $error("pin a direction ignored");

endmodule

// [pin_load.sv]
/*
  external load on one pulse pin: resolves the wire and counts high samples.
  assumes a pull-down on the pin and that clr is driven from hclk edges.
*/
`timescale 1ns/1ps

module pin_load (
  input wire logic hclk,
  input wire logic clr,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic [15:0] high_count
);
  logic level;

  // pull-down holds the wire low while nothing drives it
  assign level = pin_oe ? pin_out : 1'b0;

  always @(posedge hclk) begin
    if (clr) begin
      high_count <= 16'h0;
    end else begin
      high_count <= high_count + {15'h0, level};
    end
  end
endmodule

// [tb.sv]
/*
  self-checking bench: ahb-lite register access, pin mux, duty, flags, external clock.
  assumes the block is the only slave and its hreadyout feeds hready.
*/
`timescale 1ns/1ps

module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic ext_clk = 1'b1;
  logic [2:0] port_data = 3'h0;
  logic [2:0] port_dir = 3'h7;
  logic clr = 1'b0;
  logic ce = 1'b1;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [2:0] pout, poe;
  logic tf1, tf2;
  logic [15:0] cnt [3];
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] v;
  logic [9:0] duty [5] = '{10'h000, 10'h006, 10'h00d, 10'h010, 10'h3ff};
  int per [3];

  always #10 hclk = ~hclk;

  triple_pwm_timer_base uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .shared_ext_timer_clock(ext_clk), .port_data_bits(port_data),
    .port_direction_bits(port_dir), .pulse_out_a(pout[0]), .pulse_out_b(pout[1]),
    .pulse_out_c(pout[2]), .pulse_a_oe(poe[0]), .pulse_b_oe(poe[1]),
    .pulse_c_oe(poe[2]), .timer_one_flag(tf1), .timer_two_flag(tf2));

  pin_load load_a (.hclk(hclk), .clr(clr), .pin_out(pout[0]), .pin_oe(poe[0]),
    .high_count(cnt[0]));
  pin_load load_b (.hclk(hclk), .clr(clr), .pin_out(pout[1]), .pin_oe(poe[1]),
    .high_count(cnt[1]));
  pin_load load_c (.hclk(hclk), .clr(clr), .pin_out(pout[2]), .pin_oe(poe[2]),
    .high_count(cnt[2]));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hready is settled by the falling edge; the master acts on the next rising edge
  task automatic wait_ready(output logic [31:0] d);
    do begin
      @(negedge hclk);
      d = hrdata;
    end while (hreadyout !== 1'b1);
    @(posedge hclk);
  endtask

  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] wd,
                      output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    hsize <= pwm_timer_pkg::SIZE_WORD;
    htrans <= 2'h2;
    wait_ready(d);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready(d);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] wd);
    logic [31:0] d;
    xfer(a, 1'b1, wd, d);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    xfer(a, 1'b0, 8'h00, d);
  endtask

  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (per[i]) per[i] = 0;
    rd(12'h358, v); check("control_one", v, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    rd(12'h35c, v); check("control_two", v, 32'h0);
    rd(12'h758, v); check("control_three", v, 32'h0);
    rd(12'h15c, v); check("enables_one", v, 32'h0);
    rd(pwm_timer_pkg::ADDR_UNMAPPED, v); check("unmapped", v, 32'h0);
    port_dir <= 3'h0;
    port_data <= 3'h5;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check("port_value", {29'h0, pout}, 32'h5);
    check("port_oe_out", {29'h0, poe}, 32'h7);
    port_dir <= 3'h7;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check("port_oe_in", {29'h0, poe}, 32'h0);
    wr(12'h348, 8'h05);
    rd(12'h348, v); check("duty_before_roll", v, 32'h0);
    wr(12'h250, 8'h03);
    wr(12'h254, 8'h01);
    wr(12'h35c, 8'h33);
    wr(12'h758, 8'h01);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check("pulse_oe_forced", {29'h0, poe}, 32'h7);
    for (int k = 0; k < 5; k++) begin
      wr(12'h348, duty[k][9:2]);
      wr(12'h340, {duty[k][1:0], 6'h00});
      wr(12'h34c, duty[k][9:2]);
      wr(12'h344, {duty[k][1:0], 6'h20});
      wr(12'h744, duty[k][9:2]);
      wr(12'h740, {duty[k][1:0], k[0], 5'h00});
      per[0] = 16;
      per[1] = 8;
      per[2] = k[0] ? 8 : 16;
      repeat (64) @(posedge hclk);
      rd(12'h348, v); check("duty_after_roll", v, {24'h0, duty[k][9:2]});
      @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (128) @(posedge hclk);
      @(negedge hclk);
      for (int p = 0; p < 3; p++) begin
        v = ((duty[k] < per[p]) ? duty[k] : per[p]) * (128 / per[p]);
        check("high_count", {16'h0, cnt[p]}, v);
      end
    end
    rd(12'h158, v); check("flags_set", v, 32'h30);
    @(negedge hclk);
    check("flag_pins", {30'h0, tf2, tf1}, 32'h3);
    wr(12'h35c, 8'h30);
    wr(12'h158, 8'h00);
    rd(12'h158, v); check("flags_cleared", v, 32'h0);
    @(negedge hclk);
    check("flag_pins_clear", {30'h0, tf2, tf1}, 32'h0);
    repeat (64) @(posedge hclk);
    rd(12'h158, v); check("flags_stopped", v, 32'h0);
    wr(12'h254, 8'hff);
    wr(12'h244, 8'h00);
    wr(12'h344, 8'h20);
    wr(12'h358, 8'h02);
    wr(12'h35c, 8'h02);
    repeat (6) begin
      repeat (16) @(posedge hclk);
      ext_clk <= 1'b0;
      repeat (16) @(posedge hclk);
      ext_clk <= 1'b1;
    end
    repeat (16) @(posedge hclk);
    ce <= 1'b0;
    repeat (8) @(posedge hclk);
    ext_clk <= 1'b0;
    repeat (8) @(posedge hclk);
    ext_clk <= 1'b1;
    @(negedge hclk);
    check("ready_frozen", {31'h0, hreadyout}, 32'h0);
    repeat (8) @(posedge hclk);
    ce <= 1'b1;
    repeat (8) @(posedge hclk);
    rd(12'h244, v); check("ext_count", v, 32'h6);
    give_verdict();
  end
endmodule
